/* verilog/chip_select_pkg.sv */
// Package for the chip select decoder: decode codes, timing figures and reset values.
// Assumes a single 100 MHz system clock drives every module that imports it.
package chip_select_pkg;

  // Width of the chip select code formed from code_bit4 down to code_bit0.
  localparam int unsigned CODE_W = 5;

  // Decode codes presented on the code lines.
  localparam logic [CODE_W-1:0] CODE_ROM       = 5'h00;
  localparam logic [CODE_W-1:0] CODE_KBD_CTRL  = 5'h01;
  localparam logic [CODE_W-1:0] CODE_MATH      = 5'h02;
  localparam logic [CODE_W-1:0] CODE_PCU0      = 5'h03;
  localparam logic [CODE_W-1:0] CODE_KBD_ACK   = 5'h04;
  localparam logic [CODE_W-1:0] CODE_RTC_ALE   = 5'h05;
  localparam logic [CODE_W-1:0] CODE_RTC_WR    = 5'h06;
  localparam logic [CODE_W-1:0] CODE_RTC_RD    = 5'h07;
  localparam logic [CODE_W-1:0] CODE_FDC_DOR   = 5'h08;
  localparam logic [CODE_W-1:0] CODE_FDC_CS    = 5'h09;
  localparam logic [CODE_W-1:0] CODE_FDC_CCR   = 5'h0A;
  localparam logic [CODE_W-1:0] CODE_FDC_IDE1  = 5'h0B;
  localparam logic [CODE_W-1:0] CODE_IDE0      = 5'h0C;
  localparam logic [CODE_W-1:0] CODE_IDE1      = 5'h0D;
  localparam logic [CODE_W-1:0] CODE_SER_A     = 5'h0E;
  localparam logic [CODE_W-1:0] CODE_PAR0      = 5'h0F;
  localparam logic [CODE_W-1:0] CODE_SER_B     = 5'h10;
  localparam logic [CODE_W-1:0] CODE_PROG      = 5'h11;
  localparam logic [CODE_W-1:0] CODE_EXP_MEM   = 5'h14;
  localparam logic [CODE_W-1:0] CODE_SUSPEND   = 5'h15;
  localparam logic [CODE_W-1:0] CODE_RESUME    = 5'h16;
  localparam logic [CODE_W-1:0] CODE_PCU1      = 5'h17;

  // Reset values.
  localparam logic [CODE_W-1:0] HELD_CODE_RESET = 5'h00;
  localparam logic              OUT_RESET       = 1'b0;

  // System clock and the two square waves on chipset_clock_out.
  localparam longint unsigned CLK_HZ       = 100000000;
  localparam int unsigned     CLK_PERIOD_NS = 10;
  localparam longint unsigned FAST_HZ      = 14318000;
  localparam longint unsigned SLOW_HZ      = 32768;
  localparam int unsigned     PHASE_W      = 32;

  // Suspend refresh pulse: width and repeat period in nanoseconds.
  localparam int unsigned REFRESH_PERIOD_NS = 15260;
  localparam int unsigned REFRESH_PULSE_NS  = 1000;
  localparam int unsigned REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_PULSE_CYC  =
    (REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CNT_W = 11;

  // Power state of the suspend latch.
  typedef enum logic [0:0]
  {
    PWR_RUN     = 1'b0,
    PWR_SUSPEND = 1'b1
  } power_e;

endpackage

/* verilog/osc_clock_gen.sv */
// Square wave generator for chipset_clock_out with fast and slow rates.
// Assumes a free running system clock; the rate is picked by slow_i each cycle.
`timescale 1ns/1ps
`default_nettype none
module osc_clock_gen
(
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic slow_i,
  output logic      clk_out_o,
  output logic      fall_o
);
  import chip_select_pkg::*;

  // Phase step per system cycle for a wave that toggles twice per period.
  function automatic logic [PHASE_W-1:0] phase_inc(input longint unsigned hz);
    longint unsigned step;
    step = ((2 * hz) << PHASE_W) / CLK_HZ;
    return step[PHASE_W-1:0];
  endfunction

  localparam logic [PHASE_W-1:0] INC_FAST = phase_inc(FAST_HZ);
  localparam logic [PHASE_W-1:0] INC_SLOW = phase_inc(SLOW_HZ);

  typedef struct packed
  {
    logic [PHASE_W-1:0] phase;
    logic               wave;
    logic               fall;
  } osc_s;

  osc_s cur;
  osc_s next_cur;

  // The accumulator carry marks a half period; the rate only jitters by one system cycle.
  always_comb
  begin
    logic [PHASE_W:0] sum;
    sum = {1'b0, cur.phase} + {1'b0, (slow_i ? INC_SLOW : INC_FAST)};
    next_cur       = cur;
    next_cur.phase = sum[PHASE_W-1:0];
    next_cur.fall  = 1'b0;
    if (sum[PHASE_W])
    begin
      next_cur.wave = ~cur.wave;
      next_cur.fall = cur.wave;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      cur <= '0;
    else if (clk_en_i)
      cur <= next_cur;
  end

  assign clk_out_o = cur.wave;
  assign fall_o    = cur.fall;
endmodule
`default_nettype wire

/* verilog/refresh_pulse_gen.sv */
// Refresh pulse generator that runs only while the system is suspended.
// Assumes the 100 MHz system clock; the period restarts whenever suspend begins.
`timescale 1ns/1ps
`default_nettype none
module refresh_pulse_gen
(
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic active_i,
  output logic      pulse_o
);
  import chip_select_pkg::*;

  localparam logic [REFRESH_CNT_W-1:0] LAST =
    REFRESH_CNT_W'(REFRESH_PERIOD_CYC - 1);
  localparam logic [REFRESH_CNT_W-1:0] WIDTH =
    REFRESH_CNT_W'(REFRESH_PULSE_CYC);

  typedef struct packed
  {
    logic [REFRESH_CNT_W-1:0] count;
    logic                     pulse;
  } refresh_s;

  refresh_s cur;
  refresh_s next_cur;

  // Pulse high for the first part of every period while suspended.
  always_comb
  begin
    next_cur = cur;
    if (!active_i)
    begin
      // Parked on the last count, so the first pulse after entry is full width.
      next_cur.count = LAST;
      next_cur.pulse = 1'b0;
    end
    else
    begin
      next_cur.count = (cur.count == LAST) ? '0 : cur.count + 1'b1;
      next_cur.pulse = (next_cur.count < WIDTH); // [RULE24]
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      cur <= '0;
    else if (clk_en_i)
      cur <= next_cur;
  end

  assign pulse_o = cur.pulse;
endmodule
`default_nettype wire

/* verilog/chip_select_decoder.sv */
// Chip select decoder with suspend latch, chipset clock output and refresh pulse.
// Assumes all inputs are synchronous to clk_sys_i; every output is registered.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1 - Act only when qualified and DMA not disabling; the code accepts 16H resume without either
// RULE2 - Code bit4 is MSB; 00H enables BIOS ROM
// RULE3 - 01H selects keyboard controller
// RULE4 - 02H selects math coprocessor
// RULE5 - 03H and 17H strobe power units
// RULE6 - 04H acknowledges keyboard processor
// RULE7 - 05H asserts RTC address latch
// RULE8 - 06H RTC write, gated by IO write
// RULE9 - 07H RTC read, gated by IO read
// RULE10 - 08H selects floppy output register
// RULE11 - 09H selects floppy controller core
// RULE12 - 0AH selects floppy control register
// RULE13 - 0BH control register plus IDE block1
// RULE14 - 0CH IDE block0; high buffer if A0=0
// RULE15 - 0DH IDE low buffer and block1
// RULE16 - 0EH serial A, 0FH parallel, 10H serial B
// RULE17 - 11H programmable select, 14H expanded memory
// RULE18 - 15H latches ports on, stops 48 MHz
// RULE19 - 16H releases ports, restarts 48 MHz
// RULE20 - Use strobe-captured code when latch used
// RULE21 - Suspend entry needs qualify, write, falling edge
// RULE22 - 16H at falling edge leaves suspend
// RULE23 - Clock out fast normally, slow suspended
// RULE24 - Suspended: 1 us refresh every 15.26 us
// RULE25 - Unlisted codes do nothing
module chip_select_decoder
(
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic decode_qualify_n_i,
  input  wire logic dma_ack_disable_i,
  input  wire logic code_bit4_i,
  input  wire logic code_bit3_i,
  input  wire logic code_bit2_i,
  input  wire logic code_bit1_i,
  input  wire logic code_bit0_i,
  input  wire logic addr_latch_used_i,
  input  wire logic bus_addr_latch_strobe_i,
  input  wire logic io_write_n_i,
  input  wire logic io_read_n_i,
  input  wire logic addr_bit0_i,
  output logic      bios_rom_output_enable_o,
  output logic      keyboard_ctrl_select_o,
  output logic      math_coproc_select_o,
  output logic      pcu0_write_strobe_o,
  output logic      pcu1_write_strobe_o,
  output logic      keyboard_proc_ack_o,
  output logic      rtc_address_latch_o,
  output logic      rtc_write_strobe_o,
  output logic      rtc_read_strobe_o,
  output logic      fdc_output_reg_select_o,
  output logic      fdc_core_select_o,
  output logic      fdc_control_reg_select_o,
  output logic      ide_low_buffer_enable_o,
  output logic      ide_high_buffer_enable_o,
  output logic      ide_block0_select_o,
  output logic      ide_block1_select_o,
  output logic      serial_a_select_o,
  output logic      serial_b_select_o,
  output logic      parallel0_select_o,
  output logic      programmable_select_o,
  output logic      expanded_mem_access_o,
  output logic      companion_clk_enable_o,
  output logic      suspended_o,
  output logic      chipset_clock_out_o,
  output logic      suspend_refresh_pulse_o
);
  import chip_select_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Types and state

  // One bit per decoded output, all active high.
  typedef struct packed
  {
    logic rom;
    logic kbd_ctrl;
    logic math;
    logic pcu0;
    logic pcu1;
    logic kbd_ack;
    logic rtc_ale;
    logic rtc_wr;
    logic rtc_rd;
    logic fdc_dor;
    logic fdc_cs;
    logic fdc_ccr;
    logic ide_lo;
    logic ide_hi;
    logic ide0;
    logic ide1;
    logic ser_a;
    logic ser_b;
    logic par0;
    logic prog;
    logic exp_mem;
  } sel_s;

  typedef struct packed
  {
    power_e            power;
    logic              companion;
    logic [CODE_W-1:0] held_code;
    sel_s              sel;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic             osc_fall;
  logic [CODE_W-1:0] live_code;
  logic [CODE_W-1:0] eff_code;
  logic             qualified;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode table

  // Maps a qualified code onto the selects; bus strobes are active low.
  function automatic sel_s decode(input logic [CODE_W-1:0] code,
                                  input logic iow_n,
                                  input logic ior_n,
                                  input logic a0);
    sel_s s;
    s = '0;
    // Gated strobes follow the bus strobe level, so a released strobe drops them.
    case (code)
      CODE_ROM:      s.rom      = 1'b1; // [RULE2]
      CODE_KBD_CTRL: s.kbd_ctrl = 1'b1; // [RULE3]
      CODE_MATH:     s.math     = 1'b1; // [RULE4]
      CODE_PCU0:     s.pcu0     = 1'b1; // [RULE5]
      CODE_PCU1:     s.pcu1     = 1'b1; // [RULE5]
      CODE_KBD_ACK:  s.kbd_ack  = 1'b1; // [RULE6]
      CODE_RTC_ALE:  s.rtc_ale  = 1'b1; // [RULE7]
      CODE_RTC_WR:   s.rtc_wr   = ~iow_n; // [RULE8]
      CODE_RTC_RD:   s.rtc_rd   = ~ior_n; // [RULE9]
      CODE_FDC_DOR:  s.fdc_dor  = 1'b1; // [RULE10]
      CODE_FDC_CS:   s.fdc_cs   = 1'b1; // [RULE11]
      CODE_FDC_CCR:  s.fdc_ccr  = 1'b1; // [RULE12]
      CODE_FDC_IDE1:
      begin
        s.fdc_ccr = 1'b1; // [RULE13]
        s.ide_lo  = 1'b1; // [RULE13]
        s.ide1    = 1'b1; // [RULE13]
      end
      CODE_IDE0:
      begin
        s.ide_lo = 1'b1; // [RULE14]
        s.ide0   = 1'b1; // [RULE14]
        s.ide_hi = ~a0;  // [RULE14]
      end
      CODE_IDE1:
      begin
        s.ide_lo = 1'b1; // [RULE15]
        s.ide1   = 1'b1; // [RULE15]
      end
      CODE_SER_A:    s.ser_a    = 1'b1; // [RULE16]
      CODE_PAR0:     s.par0     = 1'b1; // [RULE16]
      CODE_SER_B:    s.ser_b    = 1'b1; // [RULE16]
      CODE_PROG:     s.prog     = 1'b1; // [RULE17]
      CODE_EXP_MEM:  s.exp_mem  = 1'b1; // [RULE17]
      default:       s          = '0;   // [RULE25]
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Code selection

  // The code bits form the code with code_bit4 as the most significant bit.
  assign live_code = {code_bit4_i, code_bit3_i, code_bit2_i, code_bit1_i,
                      code_bit0_i}; // [RULE2]

  // While the strobe is high the latch is transparent; when low it holds.
  assign eff_code = (addr_latch_used_i && !bus_addr_latch_strobe_i) ?
                    cur.held_code : live_code; // [RULE20]

  // No select decodes and suspend is not entered while DMA acknowledge disables the decoder; 16H still resumes.
  assign qualified = !decode_qualify_n_i && !dma_ack_disable_i; // [RULE1]

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  // Decoded outputs follow the code one cycle later; suspend moves only on
  // a falling edge of the chipset clock, where the code and write strobe are sampled.
  always_comb
  begin
    next_cur = cur;
    if (bus_addr_latch_strobe_i)
    begin
      next_cur.held_code = live_code; // [RULE20]
    end
    // A code seen while unqualified or under DMA disable decodes to nothing.
    next_cur.sel = qualified ?
                   decode(eff_code, io_write_n_i, io_read_n_i, addr_bit0_i) :
                   '0; // [RULE1]
    case (cur.power)
      PWR_RUN:
      begin
        if (osc_fall && qualified && !io_write_n_i && eff_code == CODE_SUSPEND)
        begin
          next_cur.power = PWR_SUSPEND; // [RULE21]
        end
      end
      PWR_SUSPEND:
      begin
        if (osc_fall && eff_code == CODE_RESUME)
        begin
          next_cur.power = PWR_RUN; // [RULE22]
        end
      end
      default: next_cur.power = PWR_RUN;
    endcase
    // The port selects stay held for the whole suspend, even under DMA.
    if (next_cur.power == PWR_SUSPEND)
    begin
      next_cur.sel.ser_a = 1'b1; // [RULE18]
      next_cur.sel.ser_b = 1'b1; // [RULE18]
      next_cur.sel.par0  = 1'b1; // [RULE18]
    end
    // The enable pin gets its own register bit, so it never comes from a gate.
    next_cur.companion = (next_cur.power == PWR_RUN); // [RULE18] [RULE19]
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cur.power     <= PWR_RUN;
      cur.held_code <= HELD_CODE_RESET;
      cur.sel       <= '0;
      cur.companion <= 1'b1;
    end
    else if (clk_en_i)
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and refresh

  // The chipset clock slows down as soon as the suspend latch is set.
  osc_clock_gen u_osc
  (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .slow_i    (cur.power == PWR_SUSPEND), // [RULE23]
    .clk_out_o (chipset_clock_out_o),
    .fall_o    (osc_fall)
  );

  // Refresh pulses run only while suspended; the period restarts at each entry.
  refresh_pulse_gen u_refresh
  (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .active_i  (cur.power == PWR_SUSPEND), // [RULE24]
    .pulse_o   (suspend_refresh_pulse_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs are register bits of the state.
  assign bios_rom_output_enable_o = cur.sel.rom;
  assign keyboard_ctrl_select_o   = cur.sel.kbd_ctrl;
  assign math_coproc_select_o     = cur.sel.math;
  assign pcu0_write_strobe_o      = cur.sel.pcu0;
  assign pcu1_write_strobe_o      = cur.sel.pcu1;
  assign keyboard_proc_ack_o      = cur.sel.kbd_ack;
  assign rtc_address_latch_o      = cur.sel.rtc_ale;
  assign rtc_write_strobe_o       = cur.sel.rtc_wr;
  assign rtc_read_strobe_o        = cur.sel.rtc_rd;
  assign fdc_output_reg_select_o  = cur.sel.fdc_dor;
  assign fdc_core_select_o        = cur.sel.fdc_cs;
  assign fdc_control_reg_select_o = cur.sel.fdc_ccr;
  assign ide_low_buffer_enable_o  = cur.sel.ide_lo;
  assign ide_high_buffer_enable_o = cur.sel.ide_hi;
  assign ide_block0_select_o      = cur.sel.ide0;
  assign ide_block1_select_o      = cur.sel.ide1;
  assign serial_a_select_o        = cur.sel.ser_a;
  assign serial_b_select_o        = cur.sel.ser_b;
  assign parallel0_select_o       = cur.sel.par0;
  assign programmable_select_o    = cur.sel.prog;
  assign expanded_mem_access_o    = cur.sel.exp_mem;

  // The companion 48 MHz clock runs whenever the suspend latch is clear.
  // It is read from its own flip-flop, so the pin cannot glitch on a decode.
  assign companion_clk_enable_o = cur.companion; // [RULE18] [RULE19]
  assign suspended_o            = (cur.power == PWR_SUSPEND);
endmodule
`default_nettype wire

/* test/chip_select_chk.sv */
// Assertion checker for the chip select decoder, watching its top ports only.
// Assumes one clock domain and the one cycle registered decode of the outputs.
`timescale 1ns/1ps
`default_nettype none
module chip_select_chk
  import chip_select_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic decode_qualify_n_i,
  input wire logic dma_ack_disable_i,
  input wire logic code_bit4_i,
  input wire logic code_bit3_i,
  input wire logic code_bit2_i,
  input wire logic code_bit1_i,
  input wire logic code_bit0_i,
  input wire logic addr_latch_used_i,
  input wire logic io_write_n_i,
  input wire logic addr_bit0_i,
  input wire logic bios_rom_output_enable_o,
  input wire logic rtc_write_strobe_o,
  input wire logic ide_low_buffer_enable_o,
  input wire logic ide_high_buffer_enable_o,
  input wire logic ide_block0_select_o,
  input wire logic serial_a_select_o,
  input wire logic serial_b_select_o,
  input wire logic parallel0_select_o,
  input wire logic companion_clk_enable_o,
  input wire logic suspended_o,
  input wire logic suspend_refresh_pulse_o
);
  logic [4:0] code;
  logic       qual;
  logic       quiet;

  // Live code only; the latched mode is judged by the bench instead.
  assign code  = {code_bit4_i, code_bit3_i, code_bit2_i, code_bit1_i, code_bit0_i};
  assign qual  = clk_en_i && !addr_latch_used_i && !decode_qualify_n_i && !dma_ack_disable_i;
  // Serial and parallel selects are left out, since suspend may hold them up.
  assign quiet = !(bios_rom_output_enable_o || rtc_write_strobe_o ||
                   ide_low_buffer_enable_o || ide_block0_select_o);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  property p_dma_off;
    clk_en_i && dma_ack_disable_i |=> quiet;
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("decode under dma disable");
  property p_rom;
    qual && code == CODE_ROM |=> bios_rom_output_enable_o;
  endproperty
  a_rom: assert property (p_rom) else $error("rom enable missing");
  property p_rtc_wr;
    qual && code == CODE_RTC_WR |=> rtc_write_strobe_o == !$past(io_write_n_i);
  endproperty
  a_rtc_wr: assert property (p_rtc_wr) else $error("rtc write gating wrong");
  property p_ide_hi;
    qual && code == CODE_IDE0 |=> ide_low_buffer_enable_o && ide_block0_select_o
      && ide_high_buffer_enable_o == !$past(addr_bit0_i);
  endproperty
  a_ide_hi: assert property (p_ide_hi) else $error("ide block0 decode wrong");
  property p_unlisted;
    qual && code == 5'h12 |=> quiet && $stable(suspended_o);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted code acted");
  property p_hold;
    suspended_o |-> serial_a_select_o && serial_b_select_o && parallel0_select_o;
  endproperty
  a_hold: assert property (p_hold) else $error("port selects dropped");
  property p_companion;
    companion_clk_enable_o == !suspended_o;
  endproperty
  a_companion: assert property (p_companion) else $error("companion clock wrong");
  property p_refresh;
    $rose(suspend_refresh_pulse_o) |-> suspended_o;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh outside suspend");
endmodule
`default_nettype wire

/* test/chipset_model.sv */
// Chipset model that drives the code, qualify and bus strobe lines of the decoder.
// Assumes the bench posts requests; the lines move only at falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module chipset_model
(
  input  wire logic        clk_sys_i,
  input  wire logic [10:0] req_i,
  output var  logic [10:0] lines_o
);
  // Idle: no code, not qualified, strobes released, latch strobe pulled high.
  initial lines_o = 11'h02D;

  // A request reaches the lines one falling edge after it is posted.
  always @(negedge clk_sys_i)
    lines_o <= req_i;
endmodule
`default_nettype wire

/* test/test_chip_select_decoder.sv */
// Self-checking bench for the chip select decoder, with a chipset model on its code lines.
// Assumes the design package, the model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_chip_select_decoder;
  import chip_select_pkg::*;
  logic        clk_sys_i;
  logic        reset_i;
  logic        clk_en_i   = 1'b1;
  logic        latch_used = 1'b0;
  logic [4:0]  code       = 5'h00;
  logic        qn         = 1'b1;
  logic        dma        = 1'b0;
  logic        iown       = 1'b1;
  logic        iorn       = 1'b1;
  logic        a0         = 1'b0;
  logic        stb        = 1'b1;
  wire  [10:0] lines;
  wire  [20:0] outs;
  wire         comp;
  wire         susp;
  wire         osc;
  wire         refr;
  int          err_count  = 0;
  int          checks     = 0;

  chipset_model chipset
  (
    .clk_sys_i (clk_sys_i),
    .req_i     ({code, qn, dma, iown, iorn, a0, stb}),
    .lines_o   (lines)
  );

  chip_select_decoder DUT
  (
    .clk_sys_i (clk_sys_i), .reset_i (reset_i), .clk_en_i (clk_en_i),
    .decode_qualify_n_i (lines[5]), .dma_ack_disable_i (lines[4]),
    .code_bit4_i (lines[10]), .code_bit3_i (lines[9]), .code_bit2_i (lines[8]),
    .code_bit1_i (lines[7]), .code_bit0_i (lines[6]), .addr_latch_used_i (latch_used),
    .bus_addr_latch_strobe_i (lines[0]), .io_write_n_i (lines[3]),
    .io_read_n_i (lines[2]), .addr_bit0_i (lines[1]),
    .bios_rom_output_enable_o (outs[20]), .keyboard_ctrl_select_o (outs[19]),
    .math_coproc_select_o (outs[18]), .pcu0_write_strobe_o (outs[17]),
    .pcu1_write_strobe_o (outs[16]), .keyboard_proc_ack_o (outs[15]),
    .rtc_address_latch_o (outs[14]), .rtc_write_strobe_o (outs[13]),
    .rtc_read_strobe_o (outs[12]), .fdc_output_reg_select_o (outs[11]),
    .fdc_core_select_o (outs[10]), .fdc_control_reg_select_o (outs[9]),
    .ide_low_buffer_enable_o (outs[8]), .ide_high_buffer_enable_o (outs[7]),
    .ide_block0_select_o (outs[6]), .ide_block1_select_o (outs[5]),
    .serial_a_select_o (outs[4]), .serial_b_select_o (outs[3]),
    .parallel0_select_o (outs[2]), .programmable_select_o (outs[1]),
    .expanded_mem_access_o (outs[0]), .companion_clk_enable_o (comp),
    .suspended_o (susp), .chipset_clock_out_o (osc), .suspend_refresh_pulse_o (refr)
  );

  // Free running 100 MHz system clock.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Expected output vector for one qualified code, most significant bit first.
  function automatic logic [20:0] exp_vec(input logic [4:0] c, input logic w, r, a);
    exp_vec = 21'h000000;
    case (c)
      CODE_ROM:      exp_vec = 21'h100000;
      CODE_KBD_CTRL: exp_vec = 21'h080000;
      CODE_MATH:     exp_vec = 21'h040000;
      CODE_PCU0:     exp_vec = 21'h020000;
      CODE_PCU1:     exp_vec = 21'h010000;
      CODE_KBD_ACK:  exp_vec = 21'h008000;
      CODE_RTC_ALE:  exp_vec = 21'h004000;
      CODE_RTC_WR:   exp_vec[13] = !w;
      CODE_RTC_RD:   exp_vec[12] = !r;
      CODE_FDC_DOR:  exp_vec = 21'h000800;
      CODE_FDC_CS:   exp_vec = 21'h000400;
      CODE_FDC_CCR:  exp_vec = 21'h000200;
      CODE_FDC_IDE1: exp_vec = 21'h000320;
      CODE_IDE0:     exp_vec = 21'h000140 | (21'(!a) << 7);
      CODE_IDE1:     exp_vec = 21'h000120;
      CODE_SER_A:    exp_vec = 21'h000010;
      CODE_PAR0:     exp_vec = 21'h000004;
      CODE_SER_B:    exp_vec = 21'h000008;
      CODE_PROG:     exp_vec = 21'h000002;
      CODE_EXP_MEM:  exp_vec = 21'h000001;
      default:       exp_vec = 21'h000000;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // A wait that used up its bound ends the run at once.
  task automatic give_up(input int n, lim);
    if (n >= lim)
    begin
      err_count++;
      $display("CHECK FAILED wait expected done seen timeout");
      print_verdict();
    end
  endtask

  // Post a request at a falling edge; its decode is settled two falling edges on.
  task automatic drive(input logic [4:0] c, input logic q, w, r, a);
    @(negedge clk_sys_i);
    code <= c;
    qn   <= q;
    iown <= w;
    iorn <= r;
    a0   <= a;
    repeat (2) @(negedge clk_sys_i);
  endtask

  task automatic count_edges(output int n);
    logic last;
    n = 0;
    last = osc;
    repeat (200)
    begin
      @(negedge clk_sys_i);
      if (osc !== last)
        n++;
      last = osc;
    end
  endtask

  // Every code except 15H and 16H back to back, then the gated codes with their gates closed.
  task automatic t_table();
    logic [4:0] g [3] = '{CODE_RTC_WR, CODE_RTC_RD, CODE_IDE0};
    for (int i = 0; i < 32; i++)
      if (5'(i) != CODE_SUSPEND && 5'(i) != CODE_RESUME)
      begin
        drive(5'(i), 1'b0, 1'b0, 1'b0, 1'b0);
        check("decode", exp_vec(5'(i), 1'b0, 1'b0, 1'b0), outs);
      end
    foreach (g[k])
    begin
      drive(g[k], 1'b0, 1'b1, 1'b1, 1'b1);
      check("gated decode", exp_vec(g[k], 1'b1, 1'b1, 1'b1), outs);
    end
    $display("table test done");
  endtask

  task automatic t_refuse();
    drive(CODE_ROM, 1'b1, 1'b1, 1'b1, 1'b0);
    check("unqualified", 0, outs);
    dma <= 1'b1;
    drive(CODE_ROM, 1'b0, 1'b1, 1'b1, 1'b0);
    check("dma disabled", 0, outs);
    dma <= 1'b0;
    $display("refuse test done");
  endtask

  // The strobe falls together with a new code; the captured code must win.
  task automatic t_latch();
    latch_used <= 1'b1;
    drive(CODE_SER_A, 1'b0, 1'b1, 1'b1, 1'b0);
    stb  <= 1'b0;
    code <= CODE_ROM;
    repeat (3) @(negedge clk_sys_i);
    check("latched code", 21'h000010, outs);
    stb        <= 1'b1;
    latch_used <= 1'b0;
    $display("latch test done");
  endtask

  task automatic t_suspend();
    int n;
    count_edges(n);
    check("fast clock", 1, n >= 56 && n <= 58);
    drive(CODE_SUSPEND, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (20) @(negedge clk_sys_i);
    check("entry without write", 0, susp);
    drive(CODE_SUSPEND, 1'b0, 1'b0, 1'b1, 1'b0);
    for (n = 0; n < 20 && susp !== 1'b1; n++)
      @(negedge clk_sys_i);
    give_up(n, 20);
    check("companion off", 0, comp);
    drive(CODE_ROM, 1'b1, 1'b1, 1'b1, 1'b0);
    check("held selects", 21'h00001C, outs);
    count_edges(n);
    check("slow clock", 1, n <= 1);
    for (n = 0; n < 1600 && refr !== 1'b1; n++)
      @(negedge clk_sys_i);
    give_up(n, 1600);
    for (n = 0; n < 200 && refr === 1'b1; n++)
      @(negedge clk_sys_i);
    check("refresh width", REFRESH_PULSE_CYC, n);
    drive(CODE_RESUME, 1'b1, 1'b1, 1'b1, 1'b0);
    for (n = 0; n < 4000 && susp !== 1'b0; n++)
      @(negedge clk_sys_i);
    give_up(n, 4000);
    @(negedge clk_sys_i);
    check("released selects", 0, outs);
    check("companion on", 1, comp);
    $display("suspend test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reset for twelve cycles, then run every scenario in turn.
  initial
  begin
    reset_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    check("companion after reset", 1, comp);
    t_table();
    t_refuse();
    t_latch();
    t_suspend();
    print_verdict();
  end
endmodule

bind chip_select_decoder chip_select_chk u_chk
(
  .clk_sys_i, .reset_i, .clk_en_i, .decode_qualify_n_i, .dma_ack_disable_i, .code_bit4_i,
  .code_bit3_i, .code_bit2_i, .code_bit1_i, .code_bit0_i, .addr_latch_used_i,
  .io_write_n_i, .addr_bit0_i, .bios_rom_output_enable_o, .rtc_write_strobe_o,
  .ide_low_buffer_enable_o, .ide_high_buffer_enable_o, .ide_block0_select_o,
  .serial_a_select_o, .serial_b_select_o, .parallel0_select_o,
  .companion_clk_enable_o, .suspended_o, .suspend_refresh_pulse_o
);
`default_nettype wire
